// [hdl/ctu_map.svh]
// Constants for the control transfer unit: reset values, widths, strides.
// Assumes inclusion by each module file of the unit, by bare name.
`ifndef CTU_MAP_SVH
`define CTU_MAP_SVH
`define CTU_IP_RST    32'h0000_0000
`define CTU_SEL_RST   16'h0000
`define CTU_SP_RST    32'h0000_0000
`define CTU_FLAGS_RST 32'h0000_0000
`define CTU_CNT_RST   32'h0000_0000
`define CTU_WORD_STEP 32'h0000_0004
`define CTU_CNT16_W   16
`define CTU_DISP8_W   8
`define CTU_SEL_W     16
`endif

// [hdl/ctu_pkg.sv]
// Types shared by the control transfer unit: operations, targets, states.
// Assumes nothing beyond a SystemVerilog compiler.
package ctu_pkg;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0, OP_JUMP = 4'h1, OP_CALL = 4'h2, OP_RET = 4'h3,
		OP_INTERRUPT_RETURN = 4'h4, OP_JCC = 4'h5, OP_JCX16Z = 4'h6,
		OP_JCX32Z = 4'h7, OP_LOOP = 4'h8, OP_LOOPE = 4'h9,
		OP_LOOPNE = 4'ha, OP_INTR = 4'hb
	} ctu_op_e;
	typedef enum logic [1:0] {
		TGT_REL = 2'h0, TGT_REG = 2'h1, TGT_MEM_NEAR = 2'h2, TGT_FAR = 2'h3
	} ctu_tgt_e;
	typedef enum logic [3:0] {
		CC_ABOVE = 4'h0, CC_ABOVE_EQ = 4'h1, CC_BELOW = 4'h2,
		CC_BELOW_EQ = 4'h3, CC_EQUAL = 4'h4, CC_NOT_EQUAL = 4'h5,
		CC_CARRY = 4'h6, CC_NO_CARRY = 4'h7, CC_PAR_EVEN = 4'h8,
		CC_PAR_ODD = 4'h9
	} ctu_cond_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_PUSH_FLAGS = 3'h1, ST_PUSH_SEL = 3'h2,
		ST_PUSH_IP = 3'h3, ST_POP_IP = 3'h4, ST_POP_SEL = 3'h5,
		ST_POP_FLAGS = 3'h6
	} ctu_state_e;
endpackage

// [hdl/ctu_cond_eval.sv]
// Condition and loop-count evaluation for conditional transfers.
// Assumes flags and count come from logic on the same clock.
`timescale 1ns/100ps
`include "ctu_map.svh"
module ctu_cond_eval (
	// Operation.
	input  wire ctu_pkg::ctu_op_e   i_op,
	input  wire ctu_pkg::ctu_cond_e i_cond,
	input  wire logic               i_addr16,
	// Status.
	input  wire logic               i_carry_flag,
	input  wire logic               i_zero_flag,
	input  wire logic               i_parity_flag,
	input  wire logic [31:0]        i_count_reg32,
	// Result.
	output logic                    o_met,
	output logic [31:0]             o_loop_count
);
	logic [`CTU_CNT16_W-1:0] cnt16;
	logic                    cnt_nz;
	logic                    cc;

	// Count decremented first, in the width chosen by addressing.
	always_comb
	begin
		cnt16 = i_count_reg32[`CTU_CNT16_W-1:0] - 16'h0001;
		if (i_addr16)
		begin
			o_loop_count = {i_count_reg32[31:`CTU_CNT16_W], cnt16};
			cnt_nz = |cnt16;
		end
		else
		begin
			o_loop_count = i_count_reg32 - 32'h0000_0001;
			cnt_nz = |o_loop_count;
		end
	end

	// Flag condition decode.
	always_comb
	begin
		case (i_cond)
			ctu_pkg::CC_ABOVE:     cc = ~(i_carry_flag | i_zero_flag);
			ctu_pkg::CC_ABOVE_EQ:  cc = ~i_carry_flag;
			ctu_pkg::CC_BELOW:     cc = i_carry_flag;
			ctu_pkg::CC_BELOW_EQ:  cc = i_carry_flag | i_zero_flag;
			ctu_pkg::CC_EQUAL:     cc = i_zero_flag;
			ctu_pkg::CC_NOT_EQUAL: cc = ~i_zero_flag;
			ctu_pkg::CC_CARRY:     cc = i_carry_flag;
			ctu_pkg::CC_NO_CARRY:  cc = ~i_carry_flag;
			ctu_pkg::CC_PAR_EVEN:  cc = i_parity_flag;
			ctu_pkg::CC_PAR_ODD:   cc = ~i_parity_flag;
			default:               cc = 1'b0;
		endcase
	end

	// Whether the conditional operation branches.
	always_comb
	begin
		case (i_op)
			ctu_pkg::OP_JCC:    o_met = cc;
			ctu_pkg::OP_JCX16Z: o_met = ~|i_count_reg32[`CTU_CNT16_W-1:0];
			ctu_pkg::OP_JCX32Z: o_met = ~|i_count_reg32;
			ctu_pkg::OP_LOOP:   o_met = cnt_nz;
			ctu_pkg::OP_LOOPE:  o_met = cnt_nz & i_zero_flag;
			ctu_pkg::OP_LOOPNE: o_met = cnt_nz & ~i_zero_flag;
			default:            o_met = 1'b0;
		endcase
	end
endmodule // ctu_cond_eval

// [hdl/ctu_target_gen.sv]
// Sequential and destination address forming.
// Assumes the current pointer and operands are stable during the request.
`timescale 1ns/100ps
`include "ctu_map.svh"
module ctu_target_gen (
	// Operands.
	input  wire ctu_pkg::ctu_tgt_e i_tgt,
	input  wire logic [31:0]       i_instr_pointer,
	input  wire logic [3:0]        i_instr_len,
	input  wire logic [31:0]       i_disp,
	input  wire logic              i_disp_is8,
	input  wire logic [31:0]       i_reg_value,
	input  wire logic [31:0]       i_mem_offset,
	// Addresses.
	output logic [31:0]            o_seq_ip,
	output logic [31:0]            o_dest_ip
);
	logic [31:0] disp_ext;

	// Next address is the base of relative targets and the return address.
	assign o_seq_ip = i_instr_pointer + {28'h000_0000, i_instr_len};

	// Short displacements are sign-extended before the add.
	assign disp_ext = i_disp_is8 ?
		{{(32-`CTU_DISP8_W){i_disp[`CTU_DISP8_W-1]}},
		 i_disp[`CTU_DISP8_W-1:0]} : i_disp;

	// Destination by target kind.
	always_comb
	begin
		case (i_tgt)
			ctu_pkg::TGT_REL: o_dest_ip = o_seq_ip + disp_ext;
			ctu_pkg::TGT_REG: o_dest_ip = i_reg_value;
			default:          o_dest_ip = i_mem_offset;
		endcase
	end
endmodule // ctu_target_gen

// [hdl/ctu_top.sv]
// Control transfer unit: next instruction address, stack pushes and pops.
// Assumes a stack memory that answers each request with a one-cycle ack.
`timescale 1ns/100ps
`include "ctu_map.svh"
module ctu_top (
	// Clock and reset.
	input  wire logic               i_sys_clk,
	input  wire logic               i_reset,
	// Decoded request.
	input  wire logic               i_start,
	input  wire ctu_pkg::ctu_op_e   i_op,
	input  wire ctu_pkg::ctu_tgt_e  i_tgt,
	input  wire ctu_pkg::ctu_cond_e i_cond,
	input  wire logic [3:0]         i_instr_len,
	input  wire logic [31:0]        i_disp,
	input  wire logic               i_disp_is8,
	input  wire logic [31:0]        i_reg_value,
	input  wire logic [31:0]        i_mem_offset,
	input  wire logic [15:0]        i_mem_sel,
	input  wire logic [15:0]        i_ret_imm,
	input  wire logic               i_addr16,
	input  wire logic               i_prot_mode,
	input  wire logic               i_far_is_gate,
	input  wire logic [31:0]        i_vector_ip,
	input  wire logic [15:0]        i_vector_sel,
	// Status from the execution datapath.
	input  wire logic               i_carry_flag,
	input  wire logic               i_zero_flag,
	input  wire logic               i_parity_flag,
	input  wire logic [31:0]        i_flags_word,
	input  wire logic [31:0]        i_count_reg32,
	// Stack memory.
	output logic                    o_stk_req,
	output logic                    o_stk_we,
	output logic [31:0]             o_stk_addr,
	output logic [31:0]             o_stk_wdata,
	input  wire logic               i_stk_ack,
	input  wire logic [31:0]        i_stk_rdata,
	// Results.
	output logic [31:0]             o_instr_pointer,
	output logic [15:0]             o_code_sel,
	output logic [31:0]             o_stack_pointer,
	output logic [31:0]             o_flags_word,
	output logic                    o_flags_we,
	output logic [31:0]             o_count_reg32,
	output logic                    o_count_we,
	output logic                    o_busy,
	output logic                    o_done,
	output logic                    o_taken,
	output logic                    o_gate_xfer
);
	ctu_pkg::ctu_state_e state;
	ctu_pkg::ctu_op_e    op_q;
	ctu_pkg::ctu_tgt_e   tgt_use;
	logic [31:0]         instr_pointer, stack_pointer, seq_ip, dest_ip;
	logic [31:0]         loop_count, tgt_ip_q, ret_ip_q, pop_ip_q, chk_rel;
	logic [15:0]         code_sel, tgt_sel_q, pop_sel_q, imm_q;
	logic                tgt_far_q, met, acc, ack, fin, is_far, gate;
	logic                cond_op, push_op, pop_op;

	// Request taken in idle; stack step completes on ack.
	assign acc = i_start & (state == ctu_pkg::ST_IDLE);
	assign ack = i_stk_ack & o_stk_req;
	assign fin = ack & (state == ctu_pkg::ST_PUSH_IP
		| state == ctu_pkg::ST_POP_FLAGS
		| (state == ctu_pkg::ST_POP_IP & op_q == ctu_pkg::OP_RET));
	assign is_far = (i_tgt == ctu_pkg::TGT_FAR);
	assign gate = i_prot_mode & i_far_is_gate & is_far;
	assign push_op = (i_op == ctu_pkg::OP_CALL) | (i_op == ctu_pkg::OP_INTR);
	assign pop_op = (i_op == ctu_pkg::OP_RET) | (i_op == ctu_pkg::OP_INTERRUPT_RETURN);
	assign cond_op = (i_op == ctu_pkg::OP_JCC) | (i_op == ctu_pkg::OP_JCX16Z)
		| (i_op == ctu_pkg::OP_JCX32Z) | (i_op == ctu_pkg::OP_LOOP)
		| (i_op == ctu_pkg::OP_LOOPE) | (i_op == ctu_pkg::OP_LOOPNE);
	// Conditional transfers are forced to near relative form.
	assign tgt_use = cond_op ? ctu_pkg::TGT_REL : i_tgt;

	// Address forming.
	ctu_target_gen u_target (
		.i_tgt           (tgt_use),
		.i_instr_pointer (instr_pointer),
		.i_instr_len     (i_instr_len),
		.i_disp          (i_disp),
		.i_disp_is8      (i_disp_is8),
		.i_reg_value     (i_reg_value),
		.i_mem_offset    (i_mem_offset),
		.o_seq_ip        (seq_ip),
		.o_dest_ip       (dest_ip)
	);

	// Condition and count evaluation.
	ctu_cond_eval u_cond (
		.i_op          (i_op),
		.i_cond        (i_cond),
		.i_addr16      (i_addr16),
		.i_carry_flag  (i_carry_flag),
		.i_zero_flag   (i_zero_flag),
		.i_parity_flag (i_parity_flag),
		.i_count_reg32 (i_count_reg32),
		.o_met         (met),
		.o_loop_count  (loop_count)
	);

	// Sequencer for stack steps.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
			state <= ctu_pkg::ST_IDLE;
		else
			case (state)
				ctu_pkg::ST_IDLE:
					if (i_start)
						case (i_op)
							ctu_pkg::OP_CALL: state <= is_far ?
								ctu_pkg::ST_PUSH_SEL : ctu_pkg::ST_PUSH_IP;
							ctu_pkg::OP_INTR: state <= ctu_pkg::ST_PUSH_FLAGS;
							ctu_pkg::OP_RET:  state <= ctu_pkg::ST_POP_IP;
							ctu_pkg::OP_INTERRUPT_RETURN: state <= ctu_pkg::ST_POP_IP;
							default:          state <= ctu_pkg::ST_IDLE;
						endcase
				ctu_pkg::ST_PUSH_FLAGS:
					if (ack)
						state <= ctu_pkg::ST_PUSH_SEL;
				ctu_pkg::ST_PUSH_SEL:
					if (ack)
						state <= ctu_pkg::ST_PUSH_IP;
				ctu_pkg::ST_POP_IP:
					if (ack)
						state <= (op_q == ctu_pkg::OP_INTERRUPT_RETURN) ?
							ctu_pkg::ST_POP_SEL : ctu_pkg::ST_IDLE;
				ctu_pkg::ST_POP_SEL:
					if (ack)
						state <= ctu_pkg::ST_POP_FLAGS;
				default:
					if (fin)
						state <= ctu_pkg::ST_IDLE;
			endcase
	end

	// Request operands held for the stack steps.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			op_q <= ctu_pkg::OP_NONE;
			tgt_ip_q <= `CTU_IP_RST;
			tgt_sel_q <= `CTU_SEL_RST;
			tgt_far_q <= 1'b0;
			ret_ip_q <= `CTU_IP_RST;
			imm_q <= 16'h0000;
		end
		else if (acc)
		begin
			op_q <= i_op;
			tgt_far_q <= is_far | (i_op == ctu_pkg::OP_INTR);
			tgt_ip_q <= (i_op == ctu_pkg::OP_INTR) ? i_vector_ip : dest_ip;
			tgt_sel_q <= (i_op == ctu_pkg::OP_INTR) ? i_vector_sel : i_mem_sel;
			ret_ip_q <= seq_ip;
			imm_q <= i_ret_imm;
		end
	end

	// Values popped before the final step.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			pop_ip_q <= `CTU_IP_RST;
			pop_sel_q <= `CTU_SEL_RST;
		end
		else if (ack & state == ctu_pkg::ST_POP_IP)
			pop_ip_q <= i_stk_rdata;
		else if (ack & state == ctu_pkg::ST_POP_SEL)
			pop_sel_q <= i_stk_rdata[`CTU_SEL_W-1:0];
	end

	// Instruction pointer and code selector.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			instr_pointer <= `CTU_IP_RST;
			code_sel <= `CTU_SEL_RST;
		end
		else if (acc)
		begin
			if (i_op == ctu_pkg::OP_JUMP & ~gate)
			begin
				instr_pointer <= dest_ip;
				if (is_far)
					code_sel <= i_mem_sel;
			end
			else if (cond_op)
				instr_pointer <= met ? dest_ip : seq_ip;
			else if (i_op == ctu_pkg::OP_NONE)
				instr_pointer <= seq_ip;
		end
		else if (fin & state == ctu_pkg::ST_PUSH_IP)
		begin
			instr_pointer <= tgt_ip_q;
			if (tgt_far_q)
				code_sel <= tgt_sel_q;
		end
		else if (fin & state == ctu_pkg::ST_POP_IP)
			instr_pointer <= i_stk_rdata;
		else if (fin)
		begin
			instr_pointer <= pop_ip_q;
			code_sel <= pop_sel_q;
		end
	end

	// Stack pointer: pre-decrement on push, post-increment on pop.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
			stack_pointer <= `CTU_SP_RST;
		else if ((acc & push_op) | (ack & (state == ctu_pkg::ST_PUSH_FLAGS
			| state == ctu_pkg::ST_PUSH_SEL)))
			stack_pointer <= stack_pointer - `CTU_WORD_STEP;
		else if (fin & op_q == ctu_pkg::OP_RET)
			stack_pointer <= stack_pointer + `CTU_WORD_STEP
				+ {16'h0000, imm_q};
		else if (ack & ~o_stk_we)
			stack_pointer <= stack_pointer + `CTU_WORD_STEP;
	end

	// Stack request, direction and write data.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			o_stk_req <= 1'b0;
			o_stk_we <= 1'b0;
			o_stk_wdata <= 32'h0000_0000;
		end
		else if (acc & (push_op | pop_op))
		begin
			o_stk_req <= 1'b1;
			o_stk_we <= push_op;
			if (i_op == ctu_pkg::OP_INTR)
				o_stk_wdata <= i_flags_word;
			else if (is_far)
				o_stk_wdata <= {16'h0000, code_sel};
			else
				o_stk_wdata <= seq_ip;
		end
		else if (fin)
			o_stk_req <= 1'b0;
		else if (ack & state == ctu_pkg::ST_PUSH_FLAGS)
			o_stk_wdata <= {16'h0000, code_sel};
		else if (ack & state == ctu_pkg::ST_PUSH_SEL)
			o_stk_wdata <= ret_ip_q;
	end

	// Count and flags write-back toward the datapath.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			o_count_reg32 <= `CTU_CNT_RST;
			o_count_we <= 1'b0;
			o_flags_word <= `CTU_FLAGS_RST;
			o_flags_we <= 1'b0;
		end
		else
		begin
			o_count_we <= acc & (i_op == ctu_pkg::OP_LOOP
				| i_op == ctu_pkg::OP_LOOPE | i_op == ctu_pkg::OP_LOOPNE);
			if (acc)
				o_count_reg32 <= loop_count;
			o_flags_we <= fin & state == ctu_pkg::ST_POP_FLAGS;
			if (fin & state == ctu_pkg::ST_POP_FLAGS)
				o_flags_word <= i_stk_rdata;
		end
	end

	// Completion status.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_taken <= 1'b0;
			o_gate_xfer <= 1'b0;
		end
		else
		begin
			o_busy <= (o_busy & ~fin) | (acc & (push_op | pop_op));
			o_done <= (acc & ~push_op & ~pop_op) | fin;
			o_taken <= (acc & (i_op == ctu_pkg::OP_JUMP | (cond_op & met)))
				| fin;
			o_gate_xfer <= acc & (i_op == ctu_pkg::OP_JUMP) & gate;
		end
	end

	assign o_instr_pointer = instr_pointer;
	assign o_code_sel = code_sel;
	assign o_stack_pointer = stack_pointer;
	assign o_stk_addr = stack_pointer;

	// Checks of the transfer behaviour.
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	assign chk_rel = instr_pointer + {28'h000_0000, i_instr_len} + i_disp;
	sequence s_push_flags;
		o_stk_req & o_stk_we & o_busy;
	endsequence
	sequence s_ret_seen;
		fin & op_q == ctu_pkg::OP_RET;
	endsequence

	jump_no_push_a: assert property (acc & i_op == ctu_pkg::OP_JUMP
		|=> ~o_stk_req & ~o_busy) else $error("jump touched the stack");
	rel_target_a: assert property (acc & i_op == ctu_pkg::OP_JUMP
		& i_tgt == ctu_pkg::TGT_REL & ~i_disp_is8 |=> o_instr_pointer
		== $past(chk_rel)) else $error("relative target wrong");
	reg_target_a: assert property (acc & i_op == ctu_pkg::OP_JUMP
		& i_tgt == ctu_pkg::TGT_REG |=> o_instr_pointer == $past(i_reg_value)
		&& $stable(o_code_sel)) else $error("register target wrong");
	far_target_a: assert property (acc & i_op == ctu_pkg::OP_JUMP
		& is_far & ~gate |=> o_code_sel == $past(i_mem_sel))
		else $error("far selector not loaded");
	call_push_a: assert property (acc & i_op == ctu_pkg::OP_CALL
		& ~is_far |=> o_stk_req & o_stk_we & o_stk_wdata == $past(seq_ip))
		else $error("call did not push return address");
	intr_flags_a: assert property (acc & i_op == ctu_pkg::OP_INTR
		|=> s_push_flags ##0 o_stk_wdata == $past(i_flags_word))
		else $error("interrupt did not push flags");
	ret_imm_a: assert property (s_ret_seen |=> o_stack_pointer
		== $past(o_stack_pointer) + `CTU_WORD_STEP + {16'h0000, $past(imm_q)}
		&& o_instr_pointer == $past(i_stk_rdata))
		else $error("return pointer or stack wrong");
	interrupt_return_flags_a: assert property (fin
		& state == ctu_pkg::ST_POP_FLAGS |=> o_flags_we
		&& o_flags_word == $past(i_stk_rdata)) else $error("flags not restored");
	jcc_fall_a: assert property (acc & cond_op & ~met
		|=> o_instr_pointer == $past(seq_ip) && ~o_stk_req && ~o_taken)
		else $error("untaken branch did not fall through");
endmodule // ctu_top

// [verification/ctu_stack_model.sv]
// Stack memory model for the far side of the control transfer unit.
// Assumes requests are held until acknowledged, all on one clock.
`timescale 1ns/100ps
module ctu_stack_model (
	// Clock.
	input  wire logic        i_sys_clk,
	// Request from the unit.
	input  wire logic        i_stk_req,
	input  wire logic        i_stk_we,
	input  wire logic [31:0] i_stk_addr,
	input  wire logic [31:0] i_stk_wdata,
	// Answer to the unit.
	output logic             o_stk_ack,
	output logic [31:0]      o_stk_rdata
);
	logic [31:0] mem [logic [31:0]];

	// Acks each access after 0 to 3 idle cycles; read data is scrambled
	// outside the ack cycle so a stale value can never pass as good.
	initial
	begin
		o_stk_ack = 1'b0;
		o_stk_rdata = 32'h5a5a_a5a5;
		forever
		begin
			@(posedge i_sys_clk);
			#1;
			if (i_stk_req)
			begin
				repeat ($urandom_range(3)) @(posedge i_sys_clk);
				#1;
				if (i_stk_we)
					mem[i_stk_addr] = i_stk_wdata;
				else if (mem.exists(i_stk_addr))
					o_stk_rdata = mem[i_stk_addr];
				o_stk_ack = 1'b1;
				@(posedge i_sys_clk);
				#1;
				o_stk_ack = 1'b0;
				o_stk_rdata = ~o_stk_rdata;
			end
		end
	end
endmodule // ctu_stack_model

// [verification/tb.sv]
// Self-checking bench for the control transfer unit with a stack model.
// Assumes ctu_pkg, ctu_top and ctu_stack_model are compiled before it.
`timescale 1ns/100ps
module tb;
	// Design inputs.
	logic               i_sys_clk = 1'b0;
	logic               i_reset, i_start, i_disp_is8, i_addr16;
	logic               i_prot_mode, i_far_is_gate, i_stk_ack;
	logic               i_carry_flag, i_zero_flag, i_parity_flag;
	ctu_pkg::ctu_op_e   i_op;
	ctu_pkg::ctu_tgt_e  i_tgt;
	ctu_pkg::ctu_cond_e i_cond;
	logic [3:0]         i_instr_len;
	logic [15:0]        i_mem_sel, i_ret_imm, i_vector_sel;
	logic [31:0]        i_disp, i_reg_value, i_mem_offset, i_vector_ip;
	logic [31:0]        i_flags_word, i_count_reg32, i_stk_rdata;
	// Design outputs.
	logic [15:0]        o_code_sel;
	logic [31:0]        o_stk_addr, o_stk_wdata, o_instr_pointer;
	logic [31:0]        o_stack_pointer, o_flags_word, o_count_reg32;
	logic               o_stk_req, o_stk_we, o_flags_we, o_count_we;
	logic               o_busy, o_done, o_taken, o_gate_xfer;
	// Bench state and expectation queues.
	logic [31:0]        e_ip, e_sp, seq, rel, nc;
	logic [15:0]        e_sel, s_sel;
	logic [9:0]         ca;
	logic [80:0]        q_res[$];
	logic [31:0]        q_cnt[$], q_flg[$], q_ret[$];
	int                 n_errors = 0, samples_checked = 0, n_done = 0, k;
	logic               quiet, met;
	logic [31:0]        cnts [5] = '{32'h0000_0001, 32'h0000_0000,
		32'h0000_0002, 32'h0001_0000, 32'h0002_0001};

	// Unit under test and its stack memory.
	ctu_top ctu_top_inst (.i_sys_clk, .i_reset, .i_start, .i_op, .i_tgt,
		.i_cond, .i_instr_len, .i_disp, .i_disp_is8, .i_reg_value,
		.i_mem_offset, .i_mem_sel, .i_ret_imm, .i_addr16, .i_prot_mode,
		.i_far_is_gate, .i_vector_ip, .i_vector_sel, .i_carry_flag,
		.i_zero_flag, .i_parity_flag, .i_flags_word, .i_count_reg32,
		.o_stk_req, .o_stk_we, .o_stk_addr, .o_stk_wdata, .i_stk_ack,
		.i_stk_rdata, .o_instr_pointer, .o_code_sel, .o_stack_pointer,
		.o_flags_word, .o_flags_we, .o_count_reg32, .o_count_we, .o_busy,
		.o_done, .o_taken, .o_gate_xfer);
	ctu_stack_model ctu_stack_model_inst (.i_sys_clk,
		.i_stk_req(o_stk_req), .i_stk_we(o_stk_we),
		.i_stk_addr(o_stk_addr), .i_stk_wdata(o_stk_wdata),
		.o_stk_ack(i_stk_ack), .o_stk_rdata(i_stk_rdata));

	// Clock of 100 MHz.
	always #5 i_sys_clk = ~i_sys_clk;

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Compares a finished operation: pointer, selector, stack, taken.
	task automatic chk_res(input logic [80:0] e, input logic [80:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected at %0t: result %h, wanted %h", $time, g, e);
		end
	endtask

	// Compares a written-back word, count or flags.
	task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected at %0t: word %h, wanted %h", $time, g, e);
		end
	endtask

	// Draws fresh operands and works out sequential and relative targets.
	task automatic rnd();
		i_instr_len = 4'($urandom_range(15, 1));
		i_disp = $urandom;
		i_disp_is8 = 1'($urandom);
		{i_carry_flag, i_zero_flag, i_parity_flag} = 3'($urandom);
		i_reg_value = $urandom;
		i_mem_offset = $urandom;
		i_mem_sel = 16'($urandom);
		i_count_reg32 = $urandom;
		seq = e_ip + 32'(i_instr_len);
		rel = seq + (i_disp_is8 ? {{24{i_disp[7]}}, i_disp[7:0]} : i_disp);
	endtask

	// Notes the expectation, issues one request and waits for its end.
	task automatic go(input ctu_pkg::ctu_op_e op, input logic [31:0] ip,
		input logic tk);
		int n;
		q_res.push_back({ip, e_sel, e_sp, tk});
		n = n_done;
		i_op = op;
		i_start = 1'b1;
		@(negedge i_sys_clk);
		i_start = 1'b0;
		// One edge passes before a following request can raise the strobe.
		@(negedge i_sys_clk);
		for (k = 0; k < 40 && n_done == n; k++)
			@(negedge i_sys_clk);
		if (n_done == n)
		begin
			n_errors++;
			$display("unexpected at %0t: operation never finished", $time);
			summarize();
		end
		e_ip = ip;
	endtask

	// Takes the oldest note whenever a result shows at the outputs while quiet is low.
	always @(negedge i_sys_clk)
	begin
		if (o_done && !quiet)
		begin
			n_done++;
			chk_res(q_res.pop_front(), {o_instr_pointer, o_code_sel,
				o_stack_pointer, o_taken});
		end
		if (o_count_we)
			chk_word(q_cnt.pop_front(), o_count_reg32);
		if (o_flags_we)
			chk_word(q_flg.pop_front(), o_flags_word);
	end

	// Main sequence.
	initial
	begin
		k = $urandom(45388);
		{e_ip, e_sp, e_sel, quiet} = '0;
		{i_reset, i_start, i_addr16, i_prot_mode, i_far_is_gate} = 5'h10;
		i_op = ctu_pkg::OP_NONE;
		i_tgt = ctu_pkg::TGT_REL;
		i_cond = ctu_pkg::CC_ABOVE;
		{i_ret_imm, i_vector_sel} = '0;
		{i_vector_ip, i_flags_word} = '0;
		rnd();
		repeat (12) @(negedge i_sys_clk);
		i_reset = 1'b0;
		// Every jump target kind, several random displacements each.
		for (int j = 0; j < 12; j++)
		begin
			rnd();
			i_tgt = ctu_pkg::ctu_tgt_e'(2'(j));
			if (j % 4 == 3)
				e_sel = i_mem_sel;
			go(ctu_pkg::OP_JUMP, (j % 4 == 0) ? rel :
				(j % 4 == 1) ? i_reg_value : i_mem_offset, 1'b1);
		end
		// Gate jump in protected mode leaves the pointer alone.
		quiet = 1'b1;
		{i_prot_mode, i_far_is_gate} = 2'h3;
		i_tgt = ctu_pkg::TGT_FAR;
		i_op = ctu_pkg::OP_JUMP;
		i_start = 1'b1;
		@(negedge i_sys_clk);
		i_start = 1'b0;
		for (k = 0; k < 8 && o_gate_xfer !== 1'b1; k++)
			@(negedge i_sys_clk);
		chk_word(32'h0000_0001, {31'h0, o_gate_xfer});
		if (o_gate_xfer !== 1'b1)
			summarize();
		@(negedge i_sys_clk);
		{quiet, i_prot_mode, i_far_is_gate} = '0;
		rnd();
		go(ctu_pkg::OP_NONE, seq, 1'b0);
		// Every condition code with random flags, far target ignored.
		for (int c = 0; c < 30; c++)
		begin
			rnd();
			i_cond = ctu_pkg::ctu_cond_e'(4'(c % 10));
			ca = {!i_parity_flag, i_parity_flag, !i_carry_flag, i_carry_flag,
				!i_zero_flag, i_zero_flag, i_carry_flag | i_zero_flag,
				i_carry_flag, !i_carry_flag, !(i_carry_flag | i_zero_flag)};
			met = ca[c % 10];
			go(ctu_pkg::OP_JCC,
				met ? rel : seq, met);
		end
		// Count-zero jumps, then the three loop kinds, over boundary counts.
		foreach (cnts[j])
			for (int o = 6; o <= 10; o++)
			begin
				rnd();
				i_count_reg32 = cnts[j];
				i_addr16 = (j >= 3);
				nc = i_addr16 ? {cnts[j][31:16], cnts[j][15:0] - 16'h0001}
					: cnts[j] - 32'h0000_0001;
				met = (o == 6) ? cnts[j][15:0] == 16'h0 : (o == 7) ?
					cnts[j] == 32'h0 : (i_addr16 ? nc[15:0] != 16'h0 :
					nc != 32'h0) && (o == 8 || (o == 9) == i_zero_flag);
				if (o >= 8)
					q_cnt.push_back(nc);
				go(ctu_pkg::ctu_op_e'(4'(o)),
					met ? rel : seq, met);
			end
		i_addr16 = 1'b0;
		// Nested calls and returns, the outer return dropping parameters.
		for (int j = 0; j < 2; j++)
		begin
			rnd();
			i_tgt = j ? ctu_pkg::TGT_REG : ctu_pkg::TGT_REL;
			q_ret.push_front(seq);
			e_sp = e_sp - 32'h0000_0004;
			go(ctu_pkg::OP_CALL, j ? i_reg_value : rel, 1'b1);
		end
		for (int j = 0; j < 2; j++)
		begin
			rnd();
			i_ret_imm = j ? 16'h0008 : 16'h0000;
			e_sp = e_sp + 32'h0000_0004 + 32'(i_ret_imm);
			go(ctu_pkg::OP_RET, q_ret.pop_front(), 1'b1);
		end
		i_ret_imm = 16'h0000;
		// Interrupt entry and return restore pointer, selector and flags.
		rnd();
		i_flags_word = $urandom;
		i_vector_ip = $urandom;
		i_vector_sel = 16'($urandom);
		q_ret.push_front(seq);
		q_flg.push_back(i_flags_word);
		s_sel = e_sel;
		e_sel = i_vector_sel;
		e_sp = e_sp - 32'h0000_000c;
		go(ctu_pkg::OP_INTR, i_vector_ip, 1'b1);
		rnd();
		e_sel = s_sel;
		e_sp = e_sp + 32'h0000_000c;
		go(ctu_pkg::OP_INTERRUPT_RETURN, q_ret.pop_front(), 1'b1);
		// A far call pushes selector and return pointer, loads both parts.
		rnd();
		i_tgt = ctu_pkg::TGT_FAR;
		e_sel = i_mem_sel;
		e_sp = e_sp - 32'h0000_0008;
		go(ctu_pkg::OP_CALL, i_mem_offset, 1'b1);
		repeat (4) @(negedge i_sys_clk);
		summarize();
	end
endmodule // tb
